// [tsr_pkg.sv]
// Package for the triggered sweep recorder: constants, modes, carriers
package tsr_pkg;

  localparam int unsigned TSR_DATA_W    = 16;
  localparam int unsigned TSR_ADDR_W    = 12;
  localparam int unsigned TSR_SEG_W     = 2;
  localparam int unsigned TSR_CNT_W     = 16;
  localparam int unsigned TSR_FIFO_D    = 16;
  localparam logic [TSR_CNT_W-1:0] TSR_DELAY_RST = 16'h0000;
  localparam logic [TSR_CNT_W-1:0] TSR_LEN_RST   = 16'h0400;

  typedef enum logic [2:0] {
    TSR_MODE_SWEEP,
    TSR_MODE_CONT_STD,
    TSR_MODE_CONT_CIRC,
    TSR_MODE_CONT_STOP,
    TSR_MODE_DUAL,
    TSR_MODE_SLOW_FAST
  } tsr_mode_t;

  typedef enum logic [1:0] {
    TSR_ST_IDLE,
    TSR_ST_STANDBY,
    TSR_ST_RUN,
    TSR_ST_HOLD
  } tsr_state_t;

  // Stream word toward host/disk
  typedef struct packed {
    logic                  slow;
    logic                  trig;
    logic [TSR_DATA_W-1:0] data;
  } tsr_stream_t;

  // RAM write port
  typedef struct packed {
    logic                  we;
    logic [TSR_SEG_W-1:0]  seg;
    logic [TSR_ADDR_W-1:0] addr;
    logic [TSR_DATA_W-1:0] data;
  } tsr_ram_wr_t;

endpackage : tsr_pkg

// [tsr_fifo.sv]
// Stream FIFO in flip-flops with valid/ready on both sides
`timescale 1ns/1ps
module tsr_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tsr_fifo

// [tsr_recorder.sv]
// Triggered sweep recorder: run/stop/pause control, segmented ring buffer, stream path
`timescale 1ns/1ps
module tsr_recorder
  import tsr_pkg::*;
#(
  parameter int unsigned DATA_W    = TSR_DATA_W,
  parameter int unsigned ADDR_W    = TSR_ADDR_W,
  parameter int unsigned SEG_W     = TSR_SEG_W,
  parameter int unsigned CNT_W     = TSR_CNT_W,
  parameter int unsigned FIFO_D    = TSR_FIFO_D
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  // Commands, one-cycle pulses from control logic
  input  wire logic                 i_run,
  input  wire logic                 i_stop,
  input  wire logic                 i_pause,
  // Configuration
  input  wire tsr_mode_t            i_mode,
  input  wire logic [CNT_W-1:0]     i_seg_len,
  input  wire logic [CNT_W-1:0]     i_delay,
  input  wire logic [SEG_W-1:0]     i_seg_count,
  input  wire logic [7:0]           i_slow_div,
  // Converter side, pins: synchronised here
  input  wire logic                 i_smp_clk,
  input  wire logic [DATA_W-1:0]    i_smp_data,
  input  wire logic                 i_trigger,
  // Onboard RAM write port
  output tsr_ram_wr_t               o_ram_wr,
  // Stream to host/disk
  output logic                      o_strm_valid,
  input  wire logic                 i_strm_ready,
  output tsr_stream_t               o_strm_data,
  output logic                      o_strm_overflow,
  // Status
  output tsr_state_t                o_state,
  output logic                      o_recording,
  output logic                      o_sweep_done,
  output logic [SEG_W-1:0]          o_done_seg,
  output logic [ADDR_W-1:0]         o_done_addr,
  output logic                      o_rec_closed,
  output logic                      o_circ_wrapped
);

  // ********************************************
  // Input synchronisers
  // ********************************************
  logic              smp_clk_m_q, smp_clk_s_q, smp_clk_p_q;
  logic              trig_m_q, trig_s_q, trig_p_q;
  logic [DATA_W-1:0] data_m_q, data_s_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      smp_clk_m_q <= 1'b0;
      smp_clk_s_q <= 1'b0;
      smp_clk_p_q <= 1'b0;
      trig_m_q    <= 1'b0;
      trig_s_q    <= 1'b0;
      trig_p_q    <= 1'b0;
      data_m_q    <= '0;
      data_s_q    <= '0;
    end else begin
      smp_clk_m_q <= i_smp_clk;
      smp_clk_s_q <= smp_clk_m_q;
      smp_clk_p_q <= smp_clk_s_q;
      trig_m_q    <= i_trigger;
      trig_s_q    <= trig_m_q;
      trig_p_q    <= trig_s_q;
      data_m_q    <= i_smp_data;
      data_s_q    <= data_m_q;
    end
  end

  // Data is stable around the time base edge, so sampling it with the edge is safe
  logic smp_tick;
  logic trig_rise;
  assign smp_tick  = smp_clk_s_q && !smp_clk_p_q;
  assign trig_rise = trig_s_q && !trig_p_q;

  // ********************************************
  // Run / stop / pause control
  // ********************************************
  tsr_state_t state_q;
  logic       end_sweep;
  logic       rec_active;
  logic       storing;
  logic       sweep_mode;

  assign sweep_mode = (i_mode == TSR_MODE_SWEEP) || (i_mode == TSR_MODE_DUAL)
                   || (i_mode == TSR_MODE_SLOW_FAST);
  assign storing    = (state_q == TSR_ST_RUN);
  assign rec_active = (state_q == TSR_ST_RUN) || (state_q == TSR_ST_HOLD);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= TSR_ST_IDLE;
    end else begin
      case (state_q)
        TSR_ST_IDLE: begin
          if (i_run) begin
            state_q <= TSR_ST_RUN;
          end else if (i_pause) begin
            state_q <= TSR_ST_STANDBY;
          end
        end
        TSR_ST_STANDBY: begin
          if (i_run) begin
            state_q <= TSR_ST_RUN;
          end else if (i_stop) begin
            state_q <= TSR_ST_IDLE;
          end
        end
        TSR_ST_RUN: begin
          if (i_stop || end_sweep) begin
            state_q <= TSR_ST_IDLE;
          end else if (i_pause) begin
            state_q <= TSR_ST_HOLD;
          end
        end
        TSR_ST_HOLD: begin
          if (i_stop) begin
            state_q <= TSR_ST_IDLE;
          end else if (i_run) begin
            state_q <= TSR_ST_RUN;
          end
        end
        default: state_q <= TSR_ST_IDLE;
      endcase
    end
  end

  // ********************************************
  // Trigger and post-trigger delay
  // ********************************************
  logic             armed_q;     // Delay running
  logic             fired_q;     // First trigger of recording seen
  logic [CNT_W-1:0] delay_q;
  logic             trig_take;
  logic             stop_trig_mode;

  // Standard continuous mode never stops on a trigger
  assign stop_trig_mode = (i_mode != TSR_MODE_CONT_STD);
  assign trig_take = storing && trig_rise && !armed_q && stop_trig_mode;

  // Zero delay ends at the trigger itself; otherwise after delay stored samples
  assign end_sweep = storing && (
      (trig_take && (i_delay == '0))
    || (armed_q && smp_tick && (delay_q == CNT_W'(1))));

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      armed_q <= 1'b0;
      delay_q <= TSR_DELAY_RST;
    end else if (!rec_active || end_sweep) begin
      armed_q <= 1'b0;
    end else if (trig_take) begin
      armed_q <= 1'b1;
      delay_q <= i_delay;
    end else if (armed_q && smp_tick && storing) begin
      delay_q <= delay_q - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      fired_q <= 1'b0;
    end else if (state_q == TSR_ST_IDLE) begin
      fired_q <= 1'b0;
    end else if (trig_take) begin
      fired_q <= 1'b1;
    end
  end

  // ********************************************
  // Segmented ring buffer writer
  // ********************************************
  logic [ADDR_W-1:0] addr_q;
  logic [SEG_W-1:0]  seg_q;
  logic [ADDR_W-1:0] last_addr;
  logic              ram_we;
  logic              wrapped_q;

  assign last_addr = (i_seg_len == '0) ? '0 : ADDR_W'(i_seg_len - 1'b1);
  assign ram_we    = storing && smp_tick && sweep_mode && !(trig_take && i_delay == '0);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_q    <= '0;
      seg_q     <= '0;
      wrapped_q <= 1'b0;
    end else if (state_q == TSR_ST_IDLE && i_run) begin
      addr_q    <= '0;
      wrapped_q <= 1'b0;
    end else if (end_sweep) begin
      addr_q    <= '0;
      wrapped_q <= 1'b0;
      seg_q     <= (seg_q >= i_seg_count) ? '0 : seg_q + 1'b1;
    end else if (ram_we) begin
      if (addr_q >= last_addr) begin
        addr_q    <= '0;
        wrapped_q <= 1'b1;
      end else begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ram_wr <= '0;
    end else begin
      o_ram_wr.we   <= ram_we;
      o_ram_wr.seg  <= seg_q;
      o_ram_wr.addr <= addr_q;
      o_ram_wr.data <= data_s_q;
    end
  end

  // Completed sweep: segment and end address handed to the host side
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sweep_done <= 1'b0;
      o_done_seg   <= '0;
      o_done_addr  <= '0;
      o_rec_closed <= 1'b0;
    end else begin
      o_sweep_done <= end_sweep && sweep_mode;
      o_rec_closed <= rec_active && (i_stop || end_sweep);
      if (end_sweep) begin
        o_done_seg  <= seg_q;
        o_done_addr <= addr_q;
      end
    end
  end

  // ********************************************
  // Continuous stream path
  // ********************************************
  logic [7:0]  slow_cnt_q;
  logic        strm_push;
  logic        strm_ready;
  logic        cont_mode;
  logic        dual_mode;
  logic        mark_q;
  tsr_stream_t strm_word;

  assign cont_mode = !sweep_mode;
  assign dual_mode = (i_mode == TSR_MODE_DUAL) || (i_mode == TSR_MODE_SLOW_FAST);

  // Slow-rate decimator for dual and slow-fast modes
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      slow_cnt_q <= '0;
    end else if (!rec_active) begin
      slow_cnt_q <= '0;
    end else if (storing && smp_tick) begin
      slow_cnt_q <= (slow_cnt_q >= i_slow_div) ? '0 : slow_cnt_q + 1'b1;
    end
  end

  assign strm_push = storing && smp_tick && !(trig_take && i_delay == '0)
                  && (cont_mode || (dual_mode && slow_cnt_q == '0));
  // Trigger lasts one cycle but slow words are sparse: hold the mark until a word carries it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mark_q <= 1'b0;
    end else if (trig_take && !fired_q && !strm_push) begin
      mark_q <= 1'b1;
    end else if (strm_push || !rec_active) begin
      mark_q <= 1'b0;
    end
  end

  assign strm_word.slow = dual_mode;
  assign strm_word.trig = mark_q || (trig_take && !fired_q);
  assign strm_word.data = data_s_q;

  // Stream cannot stall the converter; a lost word is reported, not hidden
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_strm_overflow <= 1'b0;
    end else if (state_q == TSR_ST_IDLE && i_run) begin
      o_strm_overflow <= 1'b0;
    end else if (strm_push && !strm_ready) begin
      o_strm_overflow <= 1'b1;
    end
  end

  tsr_fifo #(
    .WIDTH ($bits(tsr_stream_t)),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_in_valid  (strm_push),
    .o_in_ready  (strm_ready),
    .i_in_data   (strm_word),
    .o_out_valid (o_strm_valid),
    .i_out_ready (i_strm_ready),
    .o_out_data  (o_strm_data)
  );

  // ********************************************
  // Status
  // ********************************************
  assign o_state        = state_q;
  assign o_recording    = rec_active;
  assign o_circ_wrapped = wrapped_q;

endmodule // tsr_recorder

// [tsr_recorder_properties.sv]
// Concurrent checks on the recorder's command, write and sweep-end ports
`timescale 1ns/1ps
module tsr_recorder_properties
  import tsr_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_run,
  input wire logic        i_stop,
  input wire logic        i_pause,
  input wire tsr_ram_wr_t o_ram_wr,
  input wire tsr_state_t  o_state,
  input wire logic        o_recording,
  input wire logic        o_sweep_done,
  input wire logic        o_rec_closed
);
  // ****************
  // Helper state
  // ****************
  logic [11:0] last_q;
  logic        seen_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Previous write pointer; a fresh run or new segment may restart at zero
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      last_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (o_ram_wr.we) begin
      last_q <= o_ram_wr.addr;
      seen_q <= 1'b1;
    end
  end
  sequence s_closed;
    o_state == TSR_ST_IDLE && o_rec_closed;
  endsequence
  sequence s_start;
    o_state inside {TSR_ST_IDLE, TSR_ST_STANDBY} && i_run && !i_stop && !i_pause;
  endsequence
  // ****************
  // Properties
  // ****************
  a_run_starts: assert property (
    s_start |-> ##[1:2] o_state == TSR_ST_RUN) else $error("run did not start");
  a_stop_closes: assert property (
    o_recording && i_stop |-> ##[1:2] s_closed) else $error("stop did not close");
  a_pause_standby: assert property (
    o_state == TSR_ST_IDLE && i_pause && !i_run && !i_stop |-> ##[1:2]
    o_state == TSR_ST_STANDBY) else $error("pause gave no standby");
  a_pause_holds: assert property (
    o_state == TSR_ST_RUN && i_pause && !i_stop |-> ##[1:2]
    o_state inside {TSR_ST_HOLD, TSR_ST_IDLE}) else $error("pause gave no hold");
  a_hold_resume: assert property (
    o_state == TSR_ST_HOLD && i_run && !i_stop |-> ##[1:2] o_state == TSR_ST_RUN)
    else $error("run did not resume");
  a_write_in_run: assert property (
    o_ram_wr.we |-> $past(o_state) == TSR_ST_RUN || $past(o_state, 2) == TSR_ST_RUN)
    else $error("write outside run");
  a_addr_step: assert property (
    o_ram_wr.we && seen_q |-> o_ram_wr.addr == last_q + 12'h001 || o_ram_wr.addr == 12'h000)
    else $error("write address skipped");
  a_done_idle: assert property (
    o_sweep_done |-> o_state == TSR_ST_IDLE ##1 !o_sweep_done) else $error("bad sweep end");
endmodule // tsr_recorder_properties

// [tsr_adc_model.sv]
// Converter stand-in: free-running time base, ramp data and trigger pin
`timescale 1ns/1ps
module tsr_adc_model (
  input  wire logic   i_sys_clk,
  input  wire logic   i_fire,
  output logic        o_smp_clk,
  output logic [15:0] o_smp_data,
  output logic        o_trigger
);
  // ****************
  // Time base
  // ****************
  logic [2:0] ph_q = 3'h0;
  initial begin
    o_smp_clk = 1'b0;
    o_smp_data = 16'h0000;
    o_trigger = 1'b0;
  end
  // Eight-cycle period; data moves mid low phase so it is stable at the rise
  always @(negedge i_sys_clk) begin
    ph_q <= ph_q + 3'h1;
    o_smp_clk <= ~ph_q[2];
    if (ph_q == 3'h6) o_smp_data <= o_smp_data + 16'h0001;
    // Trigger moves just after the fall, far from any sample tick
    if (ph_q == 3'h5) o_trigger <= i_fire;
  end
endmodule // tsr_adc_model

// [tb.sv]
// Self-checking bench: commands, sweeps, hold and stalled stream
`timescale 1ns/1ps
module tb;
  import tsr_pkg::*;
  localparam int C_RUN = 0;
  localparam int C_STOP = 1;
  localparam int C_PAUSE = 2;
  logic        i_sys_clk, i_reset, i_run, i_stop, i_pause, fire_req, i_smp_clk;
  logic        i_trigger, i_strm_ready, o_strm_valid, o_strm_overflow;
  logic        o_recording, o_sweep_done, o_rec_closed, o_circ_wrapped;
  logic [15:0] i_delay, i_smp_data, last_pop;
  logic [1:0]  o_done_seg, done_seg_q;
  logic [11:0] o_done_addr;
  tsr_mode_t   i_mode;
  tsr_ram_wr_t o_ram_wr;
  tsr_stream_t o_strm_data;
  tsr_state_t  o_state;
  int          n_mismatch = 0, comparisons = 0, n_wr = 0, n_pop = 0, n_swp = 0;
  int          n_cls = 0, n_trg = 0, n0, w, k;
  logic [15:0] step = 16'h0001;
  logic        slow_exp = 1'b0;
  logic [15:0] dl [3] = '{16'h0003, 16'h0000, 16'h000A};
  tsr_recorder i_dut (
    .i_sys_clk, .i_reset, .i_run, .i_stop, .i_pause, .i_mode,
    .i_seg_len(16'h0008), .i_delay, .i_seg_count(2'h1), .i_slow_div(8'h01),
    .i_smp_clk, .i_smp_data, .i_trigger, .o_ram_wr, .o_strm_valid,
    .i_strm_ready, .o_strm_data, .o_strm_overflow, .o_state, .o_recording,
    .o_sweep_done, .o_done_seg, .o_done_addr, .o_rec_closed, .o_circ_wrapped
  );
  tsr_adc_model i_adc (
    .i_sys_clk, .i_fire(fire_req), .o_smp_clk(i_smp_clk), .o_smp_data(i_smp_data),
    .o_trigger(i_trigger)
  );
  always #25 i_sys_clk = ~i_sys_clk;
  // ****************
  // Tasks and monitor
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cmd(input int sel);
    @(negedge i_sys_clk);
    {i_run, i_stop, i_pause} = 3'h4 >> sel;
    @(negedge i_sys_clk);
    {i_run, i_stop, i_pause} = 3'h0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task automatic pull_trigger;
    fire_req = 1'b1;
    @(posedge i_trigger);
    fire_req = 1'b0;
    w = n_wr;
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    if (o_ram_wr.we) begin
      n_wr++;
      chk(o_ram_wr.data, i_smp_data, "ram data");
    end
    if (o_rec_closed) n_cls++;
    if (o_sweep_done) begin
      n_swp++;
      done_seg_q = o_done_seg;
    end
    if (o_strm_valid && i_strm_ready) begin
      if (n_pop > 0) chk(o_strm_data.data, last_pop + step, "stream order");
      chk(o_strm_data.slow, slow_exp, "slow flag");
      if (o_strm_data.trig) n_trg++;
      last_pop = o_strm_data.data;
      n_pop++;
    end
  end
  // Whole run is about a thousand cycles; 20000 means a hang
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    i_sys_clk = 1'b0;
    i_reset = 1'b1;
    {i_run, i_stop, i_pause, fire_req} = 4'h0;
    i_mode = TSR_MODE_SWEEP;
    i_delay = 16'h0003;
    i_strm_ready = 1'b1;
    repeat (20) @(negedge i_sys_clk);
    i_reset = 1'b0;
    cmd(C_PAUSE);
    chk(o_state, TSR_ST_STANDBY, "standby");
    pull_trigger();
    repeat (40) @(negedge i_sys_clk);
    chk(n_wr, w, "standby writes");
    chk(o_state, TSR_ST_STANDBY, "standby trigger");
    cmd(C_STOP);
    for (k = 0; k < 3; k++) begin
      i_delay = dl[k];
      n0 = n_wr;
      cmd(C_RUN);
      chk(o_state, TSR_ST_RUN, "run");
      w = n_wr;
      for (int i = 0; i < 200 && n_wr < w + 10; i++) @(negedge i_sys_clk);
      chk(o_circ_wrapped, 1'b1, "wrapped");
      pull_trigger();
      for (int i = 0; i < 200 && n_swp == k; i++) @(negedge i_sys_clk);
      chk(n_wr - w, dl[k], "post-trigger writes");
      chk(done_seg_q, 2'(k % 2), "segment");
      chk(o_done_addr, 12'((n_wr - n0 - (dl[k] != 16'h0000)) % 8), "end address");
      chk(o_state, TSR_ST_IDLE, "sweep end");
    end
    cmd(C_RUN);
    cmd(C_PAUSE);
    chk(o_state, TSR_ST_HOLD, "hold");
    chk(o_recording, 1'b1, "hold recording");
    pull_trigger();
    repeat (40) @(negedge i_sys_clk);
    chk(n_wr, w, "hold writes");
    chk(o_state, TSR_ST_HOLD, "hold trigger");
    cmd(C_RUN);
    chk(o_state, TSR_ST_RUN, "resume");
    repeat (40) @(negedge i_sys_clk);
    chk(n_wr > w, 1'b1, "resumed writes");
    w = n_cls;
    cmd(C_STOP);
    chk(n_cls, w + 1, "closed");
    w = n_wr;
    repeat (40) @(negedge i_sys_clk);
    chk(n_wr, w, "after stop");
    i_mode = TSR_MODE_CONT_STD;
    i_strm_ready = 1'b0;
    cmd(C_RUN);
    pull_trigger();
    repeat (200) @(negedge i_sys_clk);
    chk(o_state, TSR_ST_RUN, "stream trigger");
    chk(o_strm_overflow, 1'b1, "overflow");
    chk(n_wr, w, "stream ram");
    cmd(C_STOP);
    w = n_pop;
    i_strm_ready = 1'b1;
    repeat (40) @(negedge i_sys_clk);
    chk(n_pop - w, 16, "drained");
    chk(o_strm_valid, 1'b0, "empty");
    n_pop = 0;
    i_mode = TSR_MODE_CONT_CIRC;
    i_delay = 16'h0003;
    cmd(C_RUN);
    pull_trigger();
    w = n_pop;
    repeat (40) @(negedge i_sys_clk);
    chk(n_pop - w, 3, "lead-out words");
    chk(o_state, TSR_ST_IDLE, "lead-out end");
    chk(n_trg, 1, "trigger mark");
    n_pop = 0;
    step = 16'h0002;
    slow_exp = 1'b1;
    i_mode = TSR_MODE_DUAL;
    cmd(C_RUN);
    repeat (60) @(negedge i_sys_clk);
    pull_trigger();
    for (int i = 0; i < 200 && n_swp == 3; i++) @(negedge i_sys_clk);
    chk(n_wr - w, 3, "dual post-trigger");
    chk(n_pop >= 4, 1'b1, "slow words");
    chk(n_trg, 2, "slow trigger mark");
    n_pop = 0;
    step = 16'h0001;
    slow_exp = 1'b0;
    i_mode = TSR_MODE_CONT_STOP;
    i_delay = 16'h0000;
    cmd(C_RUN);
    pull_trigger();
    repeat (16) @(negedge i_sys_clk);
    chk(o_state, TSR_ST_IDLE, "stop on trigger");
    conclude();
  end
endmodule // tb
bind tsr_recorder tsr_recorder_properties i_props (
  .i_sys_clk, .i_reset, .i_run, .i_stop, .i_pause, .o_ram_wr, .o_state,
  .o_recording, .o_sweep_done, .o_rec_closed
);
